// File: include/crc_engine_map.svh
// Purpose: register offsets, field positions, reset values and constants
// Assumes: byte-wide special-function register port
// Notes:   definitions only
`ifndef CRC_ENGINE_MAP_SVH
`define CRC_ENGINE_MAP_SVH

// register offsets
`define CRC_OFF_CONTROL     8'hce
`define CRC_OFF_INPUT       8'hdd
`define CRC_OFF_RESULT      8'hde
`define CRC_OFF_AUTO        8'hd2
`define CRC_OFF_COUNT       8'hd3

// control register fields
`define CRC_CTL_SEL_BIT     4
`define CRC_CTL_INIT_BIT    3
`define CRC_CTL_VAL_BIT     2
`define CRC_CTL_PTR_MSB     1
`define CRC_CTL_PTR_LSB     0

// auto control register fields
`define CRC_AUTO_ARM_BIT    7
`define CRC_AUTO_DONE_BIT   6
`define CRC_AUTO_ST_MSB     4

// count register field
`define CRC_CNT_MSB         5

// reset values
`define CRC_CTL_RESET       8'h00
`define CRC_AUTO_RESET      8'h40
`define CRC_CNT_RESET       8'h00

// polynomials and presets
`define CRC_POLY16          16'h1021
`define CRC_POLY32          32'h04c11db7
`define CRC_POLY32_REFL     32'hedb88320
`define CRC_PRESET_ZERO     32'h00000000
`define CRC_PRESET_ONES     32'hffffffff

// flash sector size as a shift: 512 bytes
`define CRC_SECTOR_SHIFT    9

`endif

// File: include/crc_types_pkg.sv
// Purpose: shared types of the checksum engine
// Assumes: nothing
// Notes:   constants live in crc_engine_map.svh
package crc_types_pkg;

   // automatic scan sequencer
   typedef enum logic {
      SCAN_IDLE,
      SCAN_RUN
   } scan_state_e;

   // full width of the result register
   typedef logic [31:0] crc_word_t;

endpackage : crc_types_pkg

// File: rtl/byte_fifo.sv
// Purpose: synchronous FIFO between flash fetch and checksum fold
// Assumes: single clock, power-of-two depth
// Notes:   valid/ready on both sides, full and empty exact
`timescale 1ns/100ps

module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   // refuse shapes the pointer logic cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("byte_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;

   // full when pointers differ only in the wrap bit
   wire empty = (wr_q == rd_q);
   wire full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire push  = in_valid_i && !full;
   wire pop   = out_ready_i && !empty;

   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem[rd_q[AW-1:0]];

   // pointers
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
      end
   end

   // storage
   always_ff @(posedge ref_clk_i) begin
      if (push) mem[wr_q[AW-1:0]] <= in_data_i;
   end

endmodule : byte_fifo

// File: rtl/crc_engine_flash_scan.sv
// Purpose: byte-fed checksum engine with automatic flash sector scan
// Assumes: one system clock, register port on the same clock
// Notes:   processor is stalled while a scan runs
`timescale 1ns/100ps
`include "crc_engine_map.svh"

module crc_engine_flash_scan #(
   parameter int FLASH_AW   = 16,
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic                ref_clk_i,
   input  wire logic                rst_n_i,
   input  wire logic [7:0]          sfr_addr_i,
   input  wire logic                sfr_wr_i,
   input  wire logic                sfr_rd_i,
   input  wire logic [7:0]          sfr_wdata_i,
   output logic      [7:0]          sfr_rdata_o,
   output logic                     cpu_stall_o,
   output logic                     flash_req_o,
   output logic      [FLASH_AW-1:0] flash_addr_o,
   input  wire logic                flash_ack_i,
   input  wire logic [7:0]          flash_rdata_i
);
   localparam int CNT_W = 6 + `CRC_SECTOR_SHIFT;

   // the address must reach the last byte of sector 31 + 63
   if (FLASH_AW < 16 || FLASH_AW > 31) begin : g_bad
      $error("crc_engine_flash_scan: FLASH_AW must be 16..31");
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // byte lane reached by the pointer; 16-bit mode folds onto two lanes
   function automatic logic [1:0] lane_of(input logic [1:0] ptr, input logic sel16);
      lane_of = sel16 ? {1'b0, ptr[0]} : ptr;
   endfunction : lane_of

   // fold one byte into the result
   function automatic crc_types_pkg::crc_word_t crc_fold(
      input crc_types_pkg::crc_word_t r,
      input logic [7:0]               b,
      input logic                     sel16
   );
      crc_types_pkg::crc_word_t acc;
      acc = r;
      if (sel16) begin
         // msb-first, low 16 bits only
         acc[15:8] = acc[15:8] ^ b;
         for (int i = 0; i < 8; i++) begin
            acc[15:0] = acc[15] ? ({acc[14:0], 1'b0} ^ `CRC_POLY16)
                                : {acc[14:0], 1'b0};
         end
      end else begin
         // reflected 32-bit
         acc[7:0] = acc[7:0] ^ b;
         for (int i = 0; i < 8; i++) begin
            acc = acc[0] ? ((acc >> 1) ^ `CRC_POLY32_REFL) : (acc >> 1);
         end
      end
      crc_fold = acc;
   endfunction : crc_fold

   ////////////////////////////////////////////////////////////////////////
   // state

   logic                        sel16_q;
   logic                        val_q;
   logic [1:0]                  ptr_q;
   logic [1:0]                  ptr_d;
   logic                        arm_q;
   logic [4:0]                  start_q;
   logic [5:0]                  cnt_q;
   logic [7:0]                  in_q;
   crc_types_pkg::crc_word_t    res_q;
   crc_types_pkg::crc_word_t    res_d;
   crc_types_pkg::scan_state_e  state_q;
   logic [FLASH_AW-1:0]         addr_q;
   logic [CNT_W-1:0]            fetch_left_q;
   logic [CNT_W-1:0]            drain_left_q;
   logic [7:0]                  rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // register decode

   wire hit_ctl  = (sfr_addr_i == `CRC_OFF_CONTROL);
   wire hit_in   = (sfr_addr_i == `CRC_OFF_INPUT);
   wire hit_res  = (sfr_addr_i == `CRC_OFF_RESULT);
   wire hit_auto = (sfr_addr_i == `CRC_OFF_AUTO);
   wire hit_cnt  = (sfr_addr_i == `CRC_OFF_COUNT);

   wire wr_ctl   = sfr_wr_i && hit_ctl;
   wire wr_in    = sfr_wr_i && hit_in;
   wire wr_res   = sfr_wr_i && hit_res;
   wire wr_auto  = sfr_wr_i && hit_auto;
   wire wr_cnt   = sfr_wr_i && hit_cnt;
   wire rd_res   = sfr_rd_i && hit_res;

   wire busy      = (state_q == crc_types_pkg::SCAN_RUN);
   wire init_fire = wr_ctl && sfr_wdata_i[`CRC_CTL_INIT_BIT];
   wire scan_go   = wr_ctl && arm_q && !busy;
   wire [1:0] lane = lane_of(ptr_q, sel16_q);
   wire [7:0] res_byte = res_q[{lane, 3'b000} +: 8];

   ////////////////////////////////////////////////////////////////////////
   // scan datapath and fifo

   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic [7:0] fifo_out_data;

   wire fetch_fire = flash_req_o && flash_ack_i;
   wire drain_fire = fifo_out_valid && busy;

   // fetch one byte at a time while the fifo has room
   assign flash_req_o  = busy && (fetch_left_q != '0) && fifo_in_ready;
   assign flash_addr_o = addr_q;
   assign cpu_stall_o  = busy;

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (fetch_fire),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (flash_rdata_i),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (busy),
      .out_data_o  (fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // result next value

   wire       fold_fire = wr_in || drain_fire;
   wire [7:0] fold_byte = wr_in ? sfr_wdata_i : fifo_out_data;

   // init, byte write, fold; otherwise hold
   always_comb begin
      res_d = res_q;
      if (init_fire) begin
         res_d = sfr_wdata_i[`CRC_CTL_VAL_BIT] ? `CRC_PRESET_ONES
                                               : `CRC_PRESET_ZERO;
      end else if (wr_res) begin
         res_d[{lane, 3'b000} +: 8] = sfr_wdata_i;
      end else if (fold_fire) begin
         res_d = crc_fold(res_q, fold_byte, sel16_q);
      end
   end

   // pointer: loaded by control write, stepped by result access
   always_comb begin
      ptr_d = ptr_q;
      if (wr_ctl) begin
         ptr_d = sfr_wdata_i[`CRC_CTL_PTR_MSB:`CRC_CTL_PTR_LSB];
      end else if (wr_res || rd_res) begin
         ptr_d = ptr_q + 2'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   // control, auto and count fields; bits 7:5 of control never stored
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel16_q <= 1'b0;
         val_q   <= 1'b0;
         ptr_q   <= 2'b00;
         arm_q   <= 1'b0;
         start_q <= 5'h00;
         cnt_q   <= 6'h00;
         in_q    <= 8'h00;
         res_q   <= `CRC_PRESET_ZERO;
      end else begin
         if (wr_ctl) begin
            sel16_q <= sfr_wdata_i[`CRC_CTL_SEL_BIT];
            val_q   <= sfr_wdata_i[`CRC_CTL_VAL_BIT];
         end
         if (wr_auto) begin
            arm_q   <= sfr_wdata_i[`CRC_AUTO_ARM_BIT];
            start_q <= sfr_wdata_i[`CRC_AUTO_ST_MSB:0];
         end
         if (wr_cnt) cnt_q <= sfr_wdata_i[`CRC_CNT_MSB:0];
         if (wr_in)  in_q  <= sfr_wdata_i;
         ptr_q <= ptr_d;
         res_q <= res_d;
      end
   end

   // scan sequencer; a zero count ends after one cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q      <= crc_types_pkg::SCAN_IDLE;
         addr_q       <= '0;
         fetch_left_q <= '0;
         drain_left_q <= '0;
      end else begin
         case (state_q)
            crc_types_pkg::SCAN_IDLE: begin
               if (scan_go) begin
                  state_q      <= crc_types_pkg::SCAN_RUN;
                  addr_q       <= FLASH_AW'({start_q, 9'h000});
                  fetch_left_q <= {cnt_q, 9'h000};
                  drain_left_q <= {cnt_q, 9'h000};
               end
            end
            crc_types_pkg::SCAN_RUN: begin
               if (fetch_fire) begin
                  addr_q       <= addr_q + 1'b1;
                  fetch_left_q <= fetch_left_q - 1'b1;
               end
               if (drain_fire) drain_left_q <= drain_left_q - 1'b1;
               if (drain_left_q == '0) state_q <= crc_types_pkg::SCAN_IDLE;
            end
            default: state_q <= crc_types_pkg::SCAN_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read back

   wire [7:0] ctl_view  = {3'b000, sel16_q, 1'b0, val_q, ptr_q};
   wire [7:0] auto_view = {arm_q, !busy, 1'b0, start_q};
   wire [7:0] rd_mux    = hit_ctl  ? ctl_view
                        : hit_in   ? in_q
                        : hit_res  ? res_byte
                        : hit_auto ? auto_view
                        : hit_cnt  ? {2'b00, cnt_q}
                        : 8'h00;

   // read data registered, held between reads
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) rdata_q <= 8'h00;
      else if (sfr_rd_i) rdata_q <= rd_mux;
   end

   assign sfr_rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_scan_start;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      scan_go |=> busy && cpu_stall_o;
   endproperty
   a_scan_start: assert property (p_scan_start) else $error("armed write did not start scan");

   property p_start_addr;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      scan_go |=> flash_addr_o == FLASH_AW'({$past(start_q), 9'h000});
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("scan start address wrong");

   property p_stall_busy;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (busy && drain_left_q != '0) |=> cpu_stall_o;
   endproperty
   a_stall_busy: assert property (p_stall_busy) else $error("stall dropped before scan end");

   property p_done_flag;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (sfr_rd_i && hit_auto && busy) |=> !sfr_rdata_o[`CRC_AUTO_DONE_BIT];
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("done flag set while scanning");

   property p_ctl_top_zero;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (sfr_rd_i && hit_ctl) |=> sfr_rdata_o[7:5] == 3'b000;
   endproperty
   a_ctl_top_zero: assert property (p_ctl_top_zero) else $error("control top bits not zero");

   property p_init_ones;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (init_fire && sfr_wdata_i[`CRC_CTL_VAL_BIT]) |=> res_q == `CRC_PRESET_ONES;
   endproperty
   a_init_ones: assert property (p_init_ones) else $error("init did not load all ones");

   property p_ptr_step;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      ((rd_res || wr_res) && !wr_ctl) |=> ptr_q == $past(ptr_q) + 2'd1;
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");

   property p_read_byte;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      rd_res |=> sfr_rdata_o == $past(res_byte);
   endproperty
   a_read_byte: assert property (p_read_byte) else $error("result read wrong byte");

   property p_upper_kept;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (fold_fire && sel16_q && !init_fire && !wr_res) |=> res_q[31:16] == $past(res_q[31:16]);
   endproperty
   a_upper_kept: assert property (p_upper_kept) else $error("16-bit fold touched upper bits");

   property p_hold;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (!init_fire && !wr_res && !fold_fire) |=> $stable(res_q);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed without cause");

   property p_init_zero;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (init_fire && !sfr_wdata_i[`CRC_CTL_VAL_BIT]) |=> res_q == `CRC_PRESET_ZERO;
   endproperty
   a_init_zero: assert property (p_init_zero) else $error("init did not load all zeros");

   property p_addr_step;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      fetch_fire |=> flash_addr_o == $past(flash_addr_o) + 1'b1;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("scan address did not climb");

endmodule : crc_engine_flash_scan

// File: dv/crc_engine_flash_scan_tb.sv
// Purpose: self-checking bench for the checksum engine and its flash scan
// Assumes: register port used by tasks, flash answered by a half-rate model
// Notes:   expected checksums come from vector tables and bench-side reference folds
`timescale 1ns/100ps
`include "crc_engine_map.svh"

module crc_engine_flash_scan_tb;

   logic        ref_clk_i     = 1'b0;
   logic        rst_n_i       = 1'b0;
   logic [7:0]  sfr_addr_i    = 8'h00;
   logic        sfr_wr_i      = 1'b0;
   logic        sfr_rd_i      = 1'b0;
   logic [7:0]  sfr_wdata_i   = 8'h00;
   logic [7:0]  sfr_rdata_o;
   logic        cpu_stall_o;
   logic        flash_req_o;
   logic [15:0] flash_addr_o;
   logic        flash_ack_i   = 1'b0;
   logic [7:0]  flash_rdata_i = 8'h00;
   logic        slow_q        = 1'b0;
   logic        mon_en        = 1'b0;
   int          mon_cnt       = 0;
   int          num_errors    = 0;
   int          checked       = 0;
   logic [7:0]  rd;
   logic [31:0] e;
   logic [7:0]  vb [3][5] = '{'{8'h63, 8'h00, 8'h00, 8'h00, 8'h00},
                              '{8'haa, 8'hbb, 8'hcc, 8'h00, 8'h00},
                              '{8'h00, 8'h00, 8'haa, 8'hbb, 8'hcc}};
   int          vl [3]    = '{1, 3, 5};
   logic [31:0] x16 [3]   = '{32'hffffbd35, 32'hffff6cf6, 32'hffffb166};
   logic [31:0] x32 [3]   = '{32'hf9462090, 32'h41b207b3, 32'h78d129bc};

   crc_engine_flash_scan #(.FLASH_AW(16), .FIFO_DEPTH(16)) dut (
      .ref_clk_i     (ref_clk_i),
      .rst_n_i       (rst_n_i),
      .sfr_addr_i    (sfr_addr_i),
      .sfr_wr_i      (sfr_wr_i),
      .sfr_rd_i      (sfr_rd_i),
      .sfr_wdata_i   (sfr_wdata_i),
      .sfr_rdata_o   (sfr_rdata_o),
      .cpu_stall_o   (cpu_stall_o),
      .flash_req_o   (flash_req_o),
      .flash_addr_o  (flash_addr_o),
      .flash_ack_i   (flash_ack_i),
      .flash_rdata_i (flash_rdata_i)
   );

   ////////////////////////////////////////////////////////////////////////
   // clock, flash model and address monitor
   always #10 ref_clk_i = ~ref_clk_i;

   // flash content pattern, low address byte xor address bits 12:5
   function automatic logic [7:0] fbyte(input logic [15:0] a);
      return a[7:0] ^ a[12:5];
   endfunction : fbyte

   // answers every other cycle, so requests wait
   always @(posedge ref_clk_i) begin
      slow_q <= ~slow_q;
      if (flash_req_o && !flash_ack_i && slow_q) begin
         flash_ack_i   <= 1'b1;
         flash_rdata_i <= fbyte(flash_addr_o);
      end else begin
         flash_ack_i   <= 1'b0;
         flash_rdata_i <= ~flash_rdata_i; // no stale data between answers
      end
   end

   // fetched addresses must climb from the start address
   always @(posedge ref_clk_i) begin
      if (mon_en && flash_req_o && flash_ack_i) begin
         check({16'h0000, flash_addr_o}, 32'd1536 + mon_cnt, "scan address");
         mon_cnt++;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reference folds
   function automatic logic [31:0] c16(input logic [31:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c[15:0] ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) r = r[15] ? ((r << 1) ^ 16'h1021) : (r << 1);
      return {c[31:16], r};
   endfunction : c16

   function automatic logic [31:0] c32(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ 32'hedb88320) : (r >> 1);
      return r;
   endfunction : c32

   ////////////////////////////////////////////////////////////////////////
   // register port tasks and comparison
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      sfr_wr_i    <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      sfr_addr_i <= a;
      sfr_rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      sfr_rd_i   <= 1'b0;
      #1;
      d = sfr_rdata_o;
   endtask : rdr

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string m);
      logic [7:0] d;
      rdr(a, d);
      check({24'h0, d}, {24'h0, exp}, m);
   endtask : rchk

   // four reads from pointer 0; 16-bit mode folds lanes onto two bytes
   task automatic rres(input logic [31:0] exp, input logic s16);
      for (int i = 0; i < 4; i++) rchk(`CRC_OFF_RESULT, s16 ? exp[8*(i%2)+:8] : exp[8*i+:8], "result byte");
   endtask : rres

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      // reset values and unmapped place
      rchk(`CRC_OFF_CONTROL, 8'h00, "ctrl reset");
      rchk(`CRC_OFF_AUTO, 8'h40, "auto reset");
      rchk(`CRC_OFF_COUNT, 8'h00, "count reset");
      rchk(8'h55, 8'h00, "unmapped");
      wr(8'h55, 8'hff);
      wr(`CRC_OFF_CONTROL, 8'hf3);
      rchk(`CRC_OFF_CONTROL, 8'h13, "ctrl top bits");
      $display("test registers done");
      // table vectors in both widths, ones preset
      for (int v = 0; v < 3; v++) begin
         wr(`CRC_OFF_CONTROL, 8'h1c);
         for (int i = 0; i < vl[v]; i++) wr(`CRC_OFF_INPUT, vb[v][i]);
         rres(x16[v], 1'b1);
         wr(`CRC_OFF_CONTROL, 8'h02);
         rchk(`CRC_OFF_RESULT, 8'hff, "upper half untouched");
         rchk(`CRC_OFF_RESULT, 8'hff, "upper half untouched");
         wr(`CRC_OFF_CONTROL, 8'h0c);
         for (int i = 0; i < vl[v]; i++) wr(`CRC_OFF_INPUT, vb[v][i]);
         rres(x32[v], 1'b0);
      end
      $display("test vectors done");
      // zero preset, byte writes, hold and wrap
      wr(`CRC_OFF_CONTROL, 8'h08);
      rres(32'h00000000, 1'b0);
      for (int i = 0; i < 4; i++) wr(`CRC_OFF_RESULT, 8'(8'h11 * (i + 1)));
      rres(32'h44332211, 1'b0);
      rchk(`CRC_OFF_RESULT, 8'h11, "pointer wrap");
      wr(`CRC_OFF_INPUT, 8'h5a);
      wr(`CRC_OFF_CONTROL, 8'h00);
      rres(c32(32'h44332211, 8'h5a), 1'b0);
      $display("test result port done");
      // automatic scan of two sectors from sector 3
      wr(`CRC_OFF_CONTROL, 8'h0c);
      wr(`CRC_OFF_AUTO, 8'h03);
      wr(`CRC_OFF_AUTO, 8'h83);
      wr(`CRC_OFF_COUNT, 8'h02);
      rdr(`CRC_OFF_CONTROL, rd);
      mon_en = 1'b1;
      wr(`CRC_OFF_CONTROL, rd | 8'h00);
      #1;
      check({31'h0, cpu_stall_o}, 32'h1, "stall on trigger");
      rchk(`CRC_OFF_AUTO, 8'h83, "done low while scanning");
      for (int n = 0; n < 6000 && cpu_stall_o === 1'b1; n++) @(posedge ref_clk_i);
      #1;
      if (cpu_stall_o !== 1'b0) begin
         num_errors++;
         $display("[ERR] %0t scan never ended", $time);
         complete_run();
      end
      mon_en = 1'b0;
      check(mon_cnt, 32'd1024, "scan byte count");
      rchk(`CRC_OFF_AUTO, 8'hc3, "done after scan");
      wr(`CRC_OFF_AUTO, 8'h03);
      rchk(`CRC_OFF_AUTO, 8'h43, "disarmed");
      e = 32'hffffffff;
      for (int a = 1536; a < 2560; a++) e = c32(e, fbyte(a[15:0]));
      wr(`CRC_OFF_CONTROL, 8'h00);
      #1;
      check({31'h0, cpu_stall_o}, 32'h0, "no scan when disarmed");
      rres(e, 1'b0);
      $display("test auto scan done");
      complete_run();
   end

endmodule : crc_engine_flash_scan_tb
